// ===== design/wwcm_hold_timer.sv
// counts a fixed number of clocks while enabled
// assumes en_i stays high until done_o has been seen
module wwcm_hold_timer #(
    parameter int N = 24
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic en_i,
    output logic done_o
);

    logic [$clog2(N+1)-1:0] cnt;

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i || !en_i)
        begin
            cnt <= '0;
        end
        else if (!done_o)
        begin
            cnt <= cnt + 1'b1;
        end
    end

    assign done_o = en_i && (cnt == ($clog2(N+1))'(N - 1));

endmodule

// ===== design/wwcm_map.svh
// register layout, reset values and timing counts of the watchdog block
// assumes a 100 MHz reference clock and an 8-bit service register
`ifndef WWCM_MAP_SVH
`define WWCM_MAP_SVH

// service register field positions
`define WWCM_WIN_MSB 7
`define WWCM_WIN_LSB 6
`define WWCM_KEY_MSB 5
`define WWCM_KEY_LSB 1
`define WWCM_CM_BIT 0

// fixed key pattern and reset values
`define WWCM_KEY 5'h0c
`define WWCM_WIN_RST 2'h3
`define WWCM_CM_RST 1'h1

// window limits in idle-timer clocks
`define WWCM_LOWER_LIM 17'h0_0800
`define WWCM_UPPER_BASE 17'h0_2000

// reference clock and timing
`define WWCM_CLK_MHZ 100
`define WWCM_HOLD_CYC 24
`define WWCM_CM_TIMEOUT_US 1000

`endif

// ===== design/wwcm_pkg.sv
// types shared by the watchdog and clock monitor block
// assumes nothing beyond the map header
package wwcm_pkg;

    typedef enum logic [1:0]
    {
        WD_RUN,
        WD_DRIVE,
        WD_HOLD,
        WD_RELEASE
    } wwcm_wd_state_t;

endpackage

// ===== design/wwcm_top.sv
// windowed watchdog with instruction-clock monitor and open-drain fault pin
// assumes idle_tick_i is a one-cycle enable from the idle timer on ref_clk_i
// and that the fault pin and instruction clock arrive asynchronously
`include "wwcm_map.svh"

module wwcm_top #(
    parameter int CM_TIMEOUT_CYC = `WWCM_CM_TIMEOUT_US * `WWCM_CLK_MHZ
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic wd_option_n_i,
    input wire logic idle_tick_i,
    input wire logic low_power_i,
    input wire logic boot_rom_entry_i,
    input wire logic svc_wr_i,
    input wire logic [7:0] svc_wdata_i,
    output logic [7:0] svc_rdata_o,
    input wire logic inst_clk_i,
    input wire logic fault_pin_i,
    output logic fault_pin_o,
    output logic fault_pin_oe_o,
    output logic fault_pullup_en_o,
    output wwcm_pkg::wwcm_wd_state_t wd_state_o
);
    import wwcm_pkg::*;

    localparam int CMW = $clog2(CM_TIMEOUT_CYC + 1);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic pin_meta;
    logic pin_s;
    logic ck_meta;
    logic ck_s;
    logic ck_d;

    always_ff @(posedge ref_clk_i)
    begin
        pin_meta <= fault_pin_i;
        pin_s <= pin_meta;
    end

    always_ff @(posedge ref_clk_i)
    begin
        ck_meta <= inst_clk_i;
        ck_s <= ck_meta;
        ck_d <= ck_s;
    end

    ////////////////////////////////////////////////////////////////////////
    // service register state

    wwcm_wd_state_t state;
    logic [1:0] win_sel;
    logic cm_en;
    logic first_done;
    logic lower_waive;
    logic [16:0] win_cnt;
    logic [16:0] upper_lim;
    logic wd_active;
    logic cm_drive;
    logic fault_active;
    logic svc_take;
    logic key_ok;
    logic full_match;
    logic too_early;
    logic svc_ok;
    logic svc_err;
    logic timeout;
    logic boot_svc;
    logic restart;
    logic wd_hold_done;
    logic cm_hold_done;

    assign wd_active = !wd_option_n_i;
    // a low pin counts as asserted so a pin stuck low blocks services
    assign fault_active = (state != WD_RUN) || cm_drive || !pin_s;
    assign svc_take = svc_wr_i && wd_active && !fault_active
        && !low_power_i;
    assign key_ok = svc_wdata_i[`WWCM_KEY_MSB:`WWCM_KEY_LSB]
        == `WWCM_KEY;
    assign full_match = svc_wdata_i == {win_sel, `WWCM_KEY, cm_en};
    assign too_early = (win_cnt < `WWCM_LOWER_LIM) && !lower_waive;
    assign upper_lim = `WWCM_UPPER_BASE << win_sel;

    always_comb
    begin
        svc_ok = 1'b0;
        svc_err = 1'b0;
        if (svc_take)
        begin
            if (!first_done)
            begin
                // the first service may land anywhere in the window
                svc_ok = key_ok;
                svc_err = !key_ok;
            end
            else
            begin
                svc_ok = full_match && !too_early;
                svc_err = !full_match || too_early;
            end
        end
    end

    assign timeout = wd_active && (state == WD_RUN) && !low_power_i
        && idle_tick_i && (win_cnt == upper_lim - 17'h0_0001);
    assign boot_svc = boot_rom_entry_i && wd_active && (state == WD_RUN)
        && !svc_err;
    assign restart = (state == WD_RELEASE) && pin_s;

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            win_sel <= `WWCM_WIN_RST;
            cm_en <= `WWCM_CM_RST;
            first_done <= 1'b0;
        end
        else if (svc_ok && !first_done)
        begin
            win_sel <= svc_wdata_i[`WWCM_WIN_MSB:`WWCM_WIN_LSB];
            cm_en <= svc_wdata_i[`WWCM_CM_BIT];
            first_done <= 1'b1;
        end
    end

    // the first service after reset is free of the lower limit
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            lower_waive <= 1'b1;
        end
        else if (boot_svc)
        begin
            lower_waive <= 1'b1;
        end
        else if (svc_ok || restart)
        begin
            lower_waive <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // window counter

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            win_cnt <= '0;
        end
        else if (svc_ok || boot_svc || restart || state != WD_RUN)
        begin
            win_cnt <= '0;
        end
        else if (wd_active && idle_tick_i && !low_power_i)
        begin
            win_cnt <= win_cnt + 17'h0_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog fault sequence

    wwcm_hold_timer #(
        .N(`WWCM_HOLD_CYC)
    ) u_wd_hold (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .en_i(state == WD_HOLD),
        .done_o(wd_hold_done)
    );

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i || !wd_active)
        begin
            state <= WD_RUN;
        end
        else
        begin
            case (state)
                WD_RUN:
                begin
                    if (svc_err || timeout)
                    begin
                        state <= WD_DRIVE;
                    end
                end
                WD_DRIVE:
                begin
                    if (!pin_s)
                    begin
                        state <= WD_HOLD;
                    end
                end
                WD_HOLD:
                begin
                    if (wd_hold_done)
                    begin
                        state <= WD_RELEASE;
                    end
                end
                WD_RELEASE:
                begin
                    if (pin_s)
                    begin
                        state <= WD_RUN;
                    end
                end
                default:
                begin
                    state <= WD_RUN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock monitor
    // no edge of either polarity within the timeout is a failure; 1 ms window sits
    // between the 5 kHz pass and 10 Hz fail figures with wide margin

    logic [CMW-1:0] cm_cnt;
    logic cm_err;
    logic cm_arm;

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i || (ck_s != ck_d))
        begin
            cm_cnt <= '0;
        end
        else if (cm_cnt != CMW'(CM_TIMEOUT_CYC))
        begin
            cm_cnt <= cm_cnt + 1'b1;
        end
    end

    assign cm_err = cm_cnt == CMW'(CM_TIMEOUT_CYC);
    assign cm_arm = cm_en && wd_active;

    wwcm_hold_timer #(
        .N(`WWCM_HOLD_CYC)
    ) u_cm_hold (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .en_i(cm_drive && !cm_err),
        .done_o(cm_hold_done)
    );

    // monitor runs in halt and idle as well
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i || !cm_arm)
        begin
            cm_drive <= 1'b0;
        end
        else if (cm_err)
        begin
            cm_drive <= 1'b1;
        end
        else if (cm_hold_done)
        begin
            cm_drive <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin and read data

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            fault_pin_oe_o <= 1'b0;
        end
        else
        begin
            fault_pin_oe_o <= wd_active && (cm_drive
                || state == WD_DRIVE || state == WD_HOLD);
        end
    end

    assign fault_pin_o = 1'b0;
    assign fault_pullup_en_o = wd_active;
    assign wd_state_o = state;

    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            svc_rdata_o <= 8'h00;
        end
        else
        begin
            svc_rdata_o <= {win_sel, 5'h00, cm_en};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    property p_lower;
        svc_take && first_done && full_match && too_early
            |=> state == WD_DRIVE;
    endproperty
    a_lower: assert property (p_lower)
        else $error("early service did not fault");

    property p_upper;
        upper_lim == ((win_sel == 2'h0) ? 17'h0_2000
            : (win_sel == 2'h1) ? 17'h0_4000
            : (win_sel == 2'h2) ? 17'h0_8000 : 17'h1_0000);
    endproperty
    a_upper: assert property (p_upper)
        else $error("upper limit wrong for window select");

    property p_key;
        svc_take && !key_ok |=> state == WD_DRIVE;
    endproperty
    a_key: assert property (p_key)
        else $error("bad key did not fault");

    property p_cm_off;
        !cm_en |=> !cm_drive;
    endproperty
    a_cm_off: assert property (p_cm_off)
        else $error("disabled monitor drove the pin");

    property p_option;
        wd_option_n_i |=> !fault_pin_oe_o && !fault_pullup_en_o;
    endproperty
    a_option: assert property (p_option)
        else $error("pin driven with watchdog option off");

    property p_reset;
        $past(srst_i) |-> win_sel == 2'h3 && cm_en && state == WD_RUN;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset state wrong");

    property p_lock;
        first_done |=> $stable(win_sel) && $stable(cm_en);
    endproperty
    a_lock: assert property (p_lock)
        else $error("settings changed after first service");

    property p_hold;
        $rose(state == WD_HOLD) |-> (state == WD_HOLD)[*8]
            ##17 state == WD_RELEASE;
    endproperty
    a_hold: assert property (p_hold)
        else $error("fault hold time not 24 cycles");

    property p_timeout;
        timeout |=> state == WD_DRIVE ##1 fault_pin_oe_o;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("upper limit expiry did not fault");

    property p_ignore;
        svc_wr_i && fault_active |=> $stable(first_done)
            && $stable(win_sel);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("service taken while fault asserted");

    property p_restart;
        restart |=> state == WD_RUN && win_cnt == 17'h0_0000;
    endproperty
    a_restart: assert property (p_restart)
        else $error("window not restarted on pin high");

    property p_boot;
        boot_svc |=> win_cnt == 17'h0_0000 && lower_waive;
    endproperty
    a_boot: assert property (p_boot)
        else $error("boot rom entry did not service");

    property p_monitor;
        cm_err && cm_arm |=> ##1 fault_pin_oe_o;
    endproperty
    a_monitor: assert property (p_monitor)
        else $error("clock failure did not drive pin");

    // read data trails the stored settings by one cycle, key always zero
    property p_read;
        !$past(srst_i) |-> svc_rdata_o
            == {$past(win_sel), 5'h00, $past(cm_en)};
    endproperty
    a_read: assert property (p_read)
        else $error("key visible on read");

    c_service: cover property (svc_ok && first_done);
    c_timeout: cover property (timeout);
    c_cm_fault: cover property ($fell(cm_drive));

endmodule

// ===== dv/test_windowed_watchdog_clock_monitor.sv
// self-checking bench for the windowed watchdog and clock monitor
// assumes the design files and the map header are compiled first
`include "wwcm_map.svh"
module test_windowed_watchdog_clock_monitor;
    timeunit 1ns;
    timeprecision 1ns;
    import wwcm_pkg::*;
    localparam int CM_CYC = 200;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic opt_n = 1'b0;
    logic boot = 1'b0;
    logic tick = 1'b1;
    logic lp = 1'b0;
    logic svc_wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic inst_clk = 1'b0;
    logic inst_run = 1'b1;
    logic [7:0] rdata;
    logic pin;
    logic pin_d;
    logic oe;
    logic pull;
    wwcm_wd_state_t state;
    int bad_count = 0;
    int checked = 0;
    int seed = 32'hcea1_b0b5;
    int n;
    logic [7:0] v;
    logic [7:0] masks [3] = '{8'h40, 8'h02, 8'h01};

    wwcm_top #(.CM_TIMEOUT_CYC(CM_CYC)) u_wwcm_top (
        .ref_clk_i(clk), .srst_i(srst), .wd_option_n_i(opt_n),
        .idle_tick_i(tick), .low_power_i(lp), .boot_rom_entry_i(boot),
        .svc_wr_i(svc_wr), .svc_wdata_i(wdata), .svc_rdata_o(rdata),
        .inst_clk_i(inst_clk), .fault_pin_i(pin), .fault_pin_o(pin_d),
        .fault_pin_oe_o(oe), .fault_pullup_en_o(pull), .wd_state_o(state)
    );
    wwcm_pin_model u_wwcm_pin_model (
        .ref_clk_i(clk), .drive_i(oe), .data_i(pin_d),
        .pullup_en_i(pull), .pin_o(pin)
    );

    initial
    begin
        forever #5 clk = ~clk;
    end
    // 36 ns step puts every fifth instruction clock edge on a reference edge
    always #36 if (inst_run) inst_clk = ~inst_clk;

    task automatic chk_bit(input string name, input logic e, input logic g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %b seen %b", name, e, g);
        end
    endtask
    task automatic chk_byte(input string name, input logic [7:0] e,
                            input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
    endtask
    task automatic svc(input logic [7:0] b);
        @(posedge clk);
        svc_wr <= 1'b1;
        wdata <= b;
        @(posedge clk);
        svc_wr <= 1'b0;
    endtask
    task automatic wait_oe(input int lim);
        n = 0;
        while (oe !== 1'b1 && n < lim)
        begin
            @(negedge clk);
            n++;
        end
    endtask
    // full error pulse: drive, hold after the pin is low, release, restart
    task automatic fault_seq(input string name);
        wait_oe(12);
        chk_bit(name, 1'b1, oe);
        n = 0;
        while (pin !== 1'b0 && n < 12)
        begin
            @(negedge clk);
            n++;
        end
        chk_bit("pin low", 1'b0, pin);
        n = 0;
        while (oe === 1'b1 && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        chk_bit("release delay", 1'b1, n >= 16 && n <= 32);
        repeat (8) @(negedge clk);
        chk_bit("restart", 1'b1, state === WD_RUN && pin === 1'b1);
    endtask
    function automatic logic [7:0] shown(input logic [7:0] w);
        return {w[7:6], 5'h00, w[0]};
    endfunction

    initial
    begin
        repeat (40000) @(posedge clk);
        bad_count++;
        results();
    end

    initial
    begin
        do_reset();
        repeat (3) @(negedge clk);
        chk_byte("reset value", 8'hc1, rdata);
        chk_bit("idle oe", 1'b0, oe);
        chk_bit("pullup", 1'b1, pull);
        chk_bit("idle pin", 1'b1, pin);
        ////////////////////////////////////////////////////////////////
        v = 8'($random(seed));
        v = {v[7:6], `WWCM_KEY, v[0]};
        svc(v);
        repeat (2) @(negedge clk);
        chk_byte("first write", shown(v), rdata);
        svc(v);
        fault_seq("lower limit");
        repeat (2100) @(posedge clk);
        svc(v);
        wait_oe(20);
        chk_bit("valid service", 1'b0, oe);
        foreach (masks[i])
        begin
            repeat (2100) @(posedge clk);
            svc(v ^ masks[i]);
            fault_seq("field mismatch");
        end
        chk_byte("settings fixed", shown(v), rdata);
        ////////////////////////////////////////////////////////////////
        do_reset();
        svc({2'b00, `WWCM_KEY, 1'b0});
        wait_oe(9000);
        chk_bit("upper limit", 1'b1, n >= 8180 && n <= 8200);
        fault_seq("upper fault");
        do_reset();
        svc({2'b01, 5'h0d, 1'b1});
        fault_seq("bad key");
        chk_byte("bad key kept", 8'hc1, rdata);
        ////////////////////////////////////////////////////////////////
        do_reset();
        svc({2'b00, `WWCM_KEY, 1'b0});
        repeat (3000) @(posedge clk);
        boot <= 1'b1;
        @(posedge clk);
        boot <= 1'b0;
        svc({2'b00, `WWCM_KEY, 1'b0});
        wait_oe(20);
        chk_bit("boot waiver", 1'b0, oe);
        // low power: a bad service is ignored and the window is frozen
        @(posedge clk);
        lp <= 1'b1;
        svc(8'h00);
        wait_oe(20);
        chk_bit("halt ignores service", 1'b0, oe);
        @(posedge clk);
        lp <= 1'b0;
        tick <= 1'b0;
        repeat (2100) @(posedge clk);
        tick <= 1'b1;
        // without idle ticks the lower limit has not yet passed
        svc({2'b00, `WWCM_KEY, 1'b0});
        fault_seq("idle ticks");
        ////////////////////////////////////////////////////////////////
        inst_run = 1'b0;
        do_reset();
        wait_oe(CM_CYC + 20);
        chk_bit("monitor trip", 1'b1, oe === 1'b1 && n >= CM_CYC - 5);
        inst_run = 1'b1;
        n = 0;
        while (oe === 1'b1 && n < 80)
        begin
            @(negedge clk);
            n++;
        end
        chk_bit("monitor recover", 1'b1, n >= 16 && n <= 60);
        inst_run = 1'b0;
        @(posedge clk);
        opt_n <= 1'b1;
        do_reset();
        wait_oe(CM_CYC + 50);
        chk_bit("option off", 1'b0, oe);
        chk_bit("option pullup", 1'b0, pull);
        results();
    end
endmodule

// ===== dv/wwcm_pin_model.sv
// external reset load on the open-drain fault pin
// assumes oe high means the device sinks the pin; weak pull-up from device
module wwcm_pin_model #(
    parameter int FALL_DLY = 2
) (
    input wire logic ref_clk_i,
    input wire logic drive_i,
    input wire logic data_i,
    input wire logic pullup_en_i,
    output logic pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int lag = 0;
    logic last = 1'b1;
    always @(posedge ref_clk_i)
    begin
        lag <= drive_i ? lag + 1 : 0;
        last <= pin_o;
    end
    // the reset line discharges slowly, so the device must wait for it
    always_comb
    begin
        if (drive_i && lag >= FALL_DLY)
            pin_o = data_i;
        else if (drive_i || pullup_en_i)
            pin_o = drive_i ? last : 1'b1;
        else
            pin_o = ~last;
    end
endmodule
